// ### inc/lecr_pkg.sv
// Purpose: shared constants and carrier types for the link equalizer control registers
// Assumes: 8-bit register port with 8-bit addresses
// Notes: offsets are byte addresses of the serial control bus map
package lecr_pkg;
    localparam logic [7:0] ADDR_EQ_CONTROL = 8'h35;
    localparam logic [7:0] ADDR_PG_CLOCK = 8'h39;
    localparam logic [7:0] ADDR_DIVIDER = 8'h3a;
    localparam logic [7:0] ADDR_EQUALIZER_LEVEL = 8'h3b;
    localparam logic [7:0] ADDR_ERR_CONFIG = 8'h41;
    localparam logic [7:0] ADDR_BYPASS = 8'h44;
    localparam logic [7:0] ADDR_FLOOR = 8'h45;

    localparam logic [7:0] RESET_EQ_CONTROL = 8'h00;
    localparam logic [7:0] RESET_PG_CLOCK = 8'h00;
    localparam logic [7:0] RESET_DIVIDER = 8'h00;
    localparam logic [7:0] RESET_ERR_CONFIG = 8'h03;
    localparam logic [7:0] RESET_BYPASS = 8'h60;
    localparam logic [7:0] RESET_FLOOR = 8'h88;

    // writable bit masks; other bits are reserved and read as stored reset value or zero
    localparam logic [7:0] MASK_EQ_CONTROL = 8'h70;
    localparam logic [7:0] MASK_PG_CLOCK = 8'h02;
    localparam logic [7:0] MASK_DIVIDER = 8'hf0;
    localparam logic [7:0] MASK_ERR_CONFIG = 8'h1f;
    localparam logic [7:0] MASK_BYPASS = 8'hef;
    localparam logic [7:0] MASK_FLOOR = 8'hff;

    localparam int RESTART_BIT = 6;
    localparam int LC_OVERRIDE_BIT = 5;
    localparam int LC_MODE_BIT = 4;
    localparam int PG_INT_CLOCK_BIT = 1;
    localparam int DIV_OVERRIDE_BIT = 7;
    localparam int DIV_LSB = 4;
    localparam int ERR_ENABLE_BIT = 4;
    localparam int STAGE1_LSB = 5;
    localparam int STAGE2_LSB = 1;
    localparam int BYPASS_BIT = 0;

    // adaptation step period in pixel clock cycles
    localparam int ADAPT_STEP_CYCLES = 16;
    localparam logic [5:0] EQ_LEVEL_MAX = 6'h3f;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] address;
        logic [7:0] write_data;
    } lecr_access_type;

    typedef struct packed {
        logic embedded_clock_bit_zero;
        logic embedded_clock_bit_one;
        logic data_control_bit;
    } lecr_frame_errors_type;

    typedef struct packed {
        logic pattern_gen_internal_clock;
        logic divider_override;
        logic [2:0] divider_select;
    } lecr_clocking_type;
endpackage

// ### src/lecr_error_counter.sv
// Purpose: link error counter with lock loss decision
// Assumes: runs on the pixel clock, error flags are one-cycle per frame
// Notes: lock returns when lock_restore pulses, unless an error that loses lock arrives in the same cycle
`timescale 1ns/1ns
`default_nettype none
module lecr_error_counter #(
    parameter int WIDTH = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic count_enable,
    input wire logic [WIDTH-1:0] threshold,
    input wire lecr_pkg::lecr_frame_errors_type frame_errors,
    input wire logic lock_restore,
    output logic locked,
    output logic [WIDTH-1:0] error_count
);
    logic any_error;
    logic [WIDTH-1:0] next_count;

    assign any_error = |frame_errors;
    assign next_count = error_count + WIDTH'(1);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            error_count <= '0;
        end else if (lock_restore) begin
            error_count <= '0;
        end else if (count_enable && any_error && error_count != threshold) begin
            error_count <= next_count;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            locked <= 1'b1;
        end else if (count_enable && any_error && next_count >= threshold) begin
            locked <= 1'b0;
        end else if (!count_enable && any_error) begin
            locked <= 1'b0;
        end else if (lock_restore) begin
            locked <= 1'b1;
        end
    end
endmodule // lecr_error_counter
`default_nettype wire

// ### src/lecr_registers.sv
// Purpose: control and status registers for the receive link equalizer
// Assumes: single clock at 100 MHz used as the recovered pixel clock
// Notes: register port is the serial control bus register access
`timescale 1ns/1ns
`default_nettype none
module lecr_registers #(
    parameter int STEP_CYCLES = lecr_pkg::ADAPT_STEP_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire lecr_pkg::lecr_access_type access,
    output logic [7:0] read_data,
    input wire logic long_cable_pin,
    input wire lecr_pkg::lecr_frame_errors_type frame_errors,
    input wire logic eye_poor,
    input wire logic lock_restore,
    input wire logic [2:0] auto_divider_select,
    output logic [2:0] first_stage_setting,
    output logic [2:0] second_stage_setting,
    output logic [5:0] equalizer_level,
    output logic long_cable_mode,
    output logic adaptive_equalizer_active,
    output lecr_pkg::lecr_clocking_type clock_controls,
    output logic locked
);
    logic [7:0] eq_control;
    logic [7:0] pg_clock_select;
    logic [7:0] divider_select_reg;
    logic [7:0] error_config;
    logic [7:0] bypass_config;
    logic [7:0] floor_config;
    logic pin_meta;
    logic pin_sync;
    logic equalizer_restart;
    logic equalizer_bypass;
    logic [5:0] floor_level;
    logic [5:0] static_level;
    logic [5:0] adapt_level;
    logic [5:0] next_read_level;
    logic [$clog2(STEP_CYCLES+1)-1:0] step_count;
    logic step_pulse;
    logic [3:0] error_count;

    // adaptation mode, gray coded along restart, search and bypass
    typedef enum logic [1:0] {
        ADAPT_RESTART = 2'h0,
        ADAPT_SEARCH = 2'h1,
        ADAPT_BYPASS = 2'h3
    } lecr_adapt_mode_type;

    // write strobes and next values
    lecr_adapt_mode_type adapt_mode;
    logic write_eq_control;
    logic write_pg_clock;
    logic write_divider;
    logic write_error_config;
    logic write_bypass;
    logic write_floor;
    logic [7:0] next_read_data;
    logic [5:0] next_adapt_level;
    logic [2:0] divider_choice;
    lecr_pkg::lecr_clocking_type next_clock_controls;

    // write strobes, one for each writable register
    always_comb begin
        write_eq_control = 1'b0;
        write_pg_clock = 1'b0;
        write_divider = 1'b0;
        write_error_config = 1'b0;
        write_bypass = 1'b0;
        write_floor = 1'b0;
        if (access.write) begin
            case (access.address)
                lecr_pkg::ADDR_EQ_CONTROL: begin
                    write_eq_control = 1'b1;
                end
                lecr_pkg::ADDR_PG_CLOCK: begin
                    write_pg_clock = 1'b1;
                end
                lecr_pkg::ADDR_DIVIDER: begin
                    write_divider = 1'b1;
                end
                lecr_pkg::ADDR_ERR_CONFIG: begin
                    write_error_config = 1'b1;
                end
                lecr_pkg::ADDR_BYPASS: begin
                    write_bypass = 1'b1;
                end
                lecr_pkg::ADDR_FLOOR: begin
                    write_floor = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // equalizer control: restart, long-cable override and mode
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            eq_control <= lecr_pkg::RESET_EQ_CONTROL;
        end else if (write_eq_control) begin
            eq_control <= access.write_data & lecr_pkg::MASK_EQ_CONTROL;
        end
    end

    // pattern generator clock choice
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pg_clock_select <= lecr_pkg::RESET_PG_CLOCK;
        end else if (write_pg_clock) begin
            pg_clock_select <= access.write_data & lecr_pkg::MASK_PG_CLOCK;
        end
    end

    // audio master clock divider override and field
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            divider_select_reg <= lecr_pkg::RESET_DIVIDER;
        end else if (write_divider) begin
            divider_select_reg <= access.write_data & lecr_pkg::MASK_DIVIDER;
        end
    end

    // error counting enable and threshold, reserved bits keep their value
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            error_config <= lecr_pkg::RESET_ERR_CONFIG;
        end else if (write_error_config) begin
            error_config <= (access.write_data & lecr_pkg::MASK_ERR_CONFIG)
                | (error_config & ~lecr_pkg::MASK_ERR_CONFIG);
        end
    end

    // static stage values and bypass
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bypass_config <= lecr_pkg::RESET_BYPASS;
        end else if (write_bypass) begin
            bypass_config <= access.write_data & lecr_pkg::MASK_BYPASS;
        end
    end

    // floor field
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            floor_config <= lecr_pkg::RESET_FLOOR;
        end else if (write_floor) begin
            floor_config <= access.write_data & lecr_pkg::MASK_FLOOR;
        end
    end

    // read selection
    // unmapped addresses read zero
    always_comb begin
        case (access.address)
            lecr_pkg::ADDR_EQ_CONTROL: next_read_data = eq_control;
            lecr_pkg::ADDR_PG_CLOCK: next_read_data = pg_clock_select;
            lecr_pkg::ADDR_DIVIDER: next_read_data = divider_select_reg;
            lecr_pkg::ADDR_EQUALIZER_LEVEL: next_read_data = {2'b00, equalizer_level};
            lecr_pkg::ADDR_ERR_CONFIG: next_read_data = error_config;
            lecr_pkg::ADDR_BYPASS: next_read_data = bypass_config;
            lecr_pkg::ADDR_FLOOR: next_read_data = floor_config;
            default: next_read_data = 8'h00;
        endcase
    end

    // read data holds until the next read
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= 8'h00;
        end else if (access.read) begin
            read_data <= next_read_data;
        end
    end

    // configuration pin synchroniser
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= long_cable_pin;
            pin_sync <= pin_meta;
        end
    end

    always_comb begin
        if (eq_control[lecr_pkg::LC_OVERRIDE_BIT]) begin
            long_cable_mode = eq_control[lecr_pkg::LC_MODE_BIT];
        end else begin
            long_cable_mode = pin_sync;
        end
    end

    assign equalizer_restart = eq_control[lecr_pkg::RESTART_BIT];
    assign equalizer_bypass = bypass_config[lecr_pkg::BYPASS_BIT];
    assign adaptive_equalizer_active = !equalizer_bypass;

    // floor is the floor field in long-cable mode, otherwise the lowest level
    assign floor_level = long_cable_mode ? {2'b00, floor_config[3:0]} : 6'h00;
    assign static_level = {bypass_config[7:5], bypass_config[3:1]};

    // adaptation step divider
    assign step_pulse = (step_count == ($clog2(STEP_CYCLES+1))'(STEP_CYCLES - 1));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            step_count <= '0;
        end else if (step_pulse) begin
            step_count <= '0;
        end else begin
            step_count <= step_count + 1'b1;
        end
    end

    // restart wins over bypass
    always_comb begin
        if (equalizer_restart) begin
            adapt_mode = ADAPT_RESTART;
        end else if (equalizer_bypass) begin
            adapt_mode = ADAPT_BYPASS;
        end else begin
            adapt_mode = ADAPT_SEARCH;
        end
    end

    // adaptive search: climbs while the eye is poor, never below floor
    always_comb begin
        next_adapt_level = adapt_level;
        case (adapt_mode)
            ADAPT_RESTART: begin
                next_adapt_level = floor_level;
            end
            ADAPT_BYPASS: begin
                next_adapt_level = adapt_level;
            end
            ADAPT_SEARCH: begin
                if (adapt_level < floor_level) begin
                    next_adapt_level = floor_level;
                end else if (step_pulse && eye_poor) begin
                    if (adapt_level == lecr_pkg::EQ_LEVEL_MAX) begin
                        next_adapt_level = floor_level;
                    end else begin
                        next_adapt_level = adapt_level + 6'h01;
                    end
                end
            end
            default: begin
                next_adapt_level = floor_level;
            end
        endcase
    end

    // level register for the adaptive search
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            adapt_level <= 6'h00;
        end else begin
            adapt_level <= next_adapt_level;
        end
    end

    always_comb begin
        if (equalizer_bypass) begin
            next_read_level = static_level;
        end else begin
            next_read_level = adapt_level;
        end
    end

    // level in use, for status readback
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            equalizer_level <= 6'h00;
        end else begin
            equalizer_level <= next_read_level;
        end
    end

    // stage settings split from the same level
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            first_stage_setting <= 3'h0;
            second_stage_setting <= 3'h0;
        end else begin
            first_stage_setting <= next_read_level[5:3];
            second_stage_setting <= next_read_level[2:0];
        end
    end

    // divider choice: field when overridden, automatic selection otherwise
    assign divider_choice = divider_select_reg[lecr_pkg::DIV_OVERRIDE_BIT]
        ? divider_select_reg[lecr_pkg::DIV_LSB +: 3] : auto_divider_select;

    always_comb begin
        next_clock_controls = '0;
        next_clock_controls.pattern_gen_internal_clock =
            pg_clock_select[lecr_pkg::PG_INT_CLOCK_BIT];
        next_clock_controls.divider_override = divider_select_reg[lecr_pkg::DIV_OVERRIDE_BIT];
        next_clock_controls.divider_select = divider_choice;
    end

    // registered so the clock selections change cleanly
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clock_controls <= '0;
        end else begin
            clock_controls <= next_clock_controls;
        end
    end

    lecr_error_counter #(
        .WIDTH(4)
    ) error_counter (
        .clock(clock),
        .reset_n(reset_n),
        .count_enable(error_config[lecr_pkg::ERR_ENABLE_BIT]),
        .threshold(error_config[3:0]),
        .frame_errors(frame_errors),
        .lock_restore(lock_restore),
        .locked(locked),
        .error_count(error_count)
    );
endmodule // lecr_registers
`default_nettype wire

// ### dv/lecr_monitor.sv
// Purpose: checker for the equalizer control registers
// Assumes: single clock, async active-low reset
// Notes: bound to the top register module
`timescale 1ns/1ns
`default_nettype none
module lecr_monitor #(
    parameter int STEP_CYCLES = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire lecr_pkg::lecr_access_type access,
    input wire logic [7:0] read_data,
    input wire lecr_pkg::lecr_frame_errors_type frame_errors,
    input wire logic [2:0] first_stage_setting,
    input wire logic [2:0] second_stage_setting,
    input wire logic [5:0] equalizer_level,
    input wire logic long_cable_mode,
    input wire logic adaptive_equalizer_active,
    input wire lecr_pkg::lecr_clocking_type clock_controls,
    input wire logic locked
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    logic count_on;
    logic [7:0] wa;
    logic [7:0] wd;
    assign wa = access.write ? access.address : 8'h00;
    assign wd = access.write_data;
    // mirror of the count enable bit
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_on <= 1'b0;
        end else if (wa == 8'h41) begin
            count_on <= wd[4];
        end
    end
    a_bypass_flag: assert property (
        wa == 8'h44 |=> adaptive_equalizer_active == !$past(wd[0])) else $error("bypass flag");
    a_bypass_level: assert property (
        wa == 8'h44 && wd[0] |-> ##2 equalizer_level == {$past(wd[7:5], 2), $past(wd[3:1], 2)})
        else $error("static level");
    a_stage_split: assert property (
        {first_stage_setting, second_stage_setting} == equalizer_level) else $error("stages");
    a_status_read: assert property (
        access.read && access.address == 8'h3b |=> read_data == {2'b00, $past(equalizer_level)})
        else $error("status read");
    a_lc_override: assert property (
        wa == 8'h35 && wd[5] |=> long_cable_mode == $past(wd[4])) else $error("long cable");
    a_pg_clock: assert property (
        wa == 8'h39 |-> ##2 clock_controls.pattern_gen_internal_clock == $past(wd[1], 2))
        else $error("pattern clock");
    a_div_select: assert property (
        wa == 8'h3a && wd[7] |-> ##2 clock_controls.divider_select == $past(wd[6:4], 2))
        else $error("divider select");
    a_lock_first: assert property (
        !count_on && |frame_errors |=> !locked) else $error("lock kept on error");
    c_bypass: cover property (wa == 8'h44 && wd[0]);
    c_lock_loss: cover property ($fell(locked));
    c_status: cover property (access.read && access.address == 8'h3b);
endmodule // lecr_monitor
bind lecr_registers lecr_monitor #(.STEP_CYCLES(STEP_CYCLES)) u_monitor (.clock, .reset_n,
    .access, .read_data, .frame_errors, .first_stage_setting, .second_stage_setting,
    .equalizer_level, .long_cable_mode, .adaptive_equalizer_active, .clock_controls, .locked);
`default_nettype wire

// ### dv/lecr_host.sv
// Purpose: host controller model on the register port
// Assumes: requests change at falling edges
// Notes: idle address and data are inverted so stale values never match
`timescale 1ns/1ns
`default_nettype none
module lecr_host (
    input wire logic clock,
    input wire logic [7:0] read_data,
    output var lecr_pkg::lecr_access_type access
);
    initial access = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        access = '{write: 1'b1, read: 1'b0, address: a, write_data: d};
        @(negedge clock);
        access = '{write: 1'b0, read: 1'b0, address: ~a, write_data: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        access = '{write: 1'b0, read: 1'b1, address: a, write_data: ~a};
        @(negedge clock);
        d = read_data;
        access = '{write: 1'b0, read: 1'b0, address: ~a, write_data: a};
    endtask
endmodule // lecr_host
`default_nettype wire

// ### dv/testbench.sv
// Purpose: self-checking bench for the equalizer control registers
// Assumes: host model drives the register port at falling edges
// Notes: adaptation step shortened to 4 cycles
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clock;
    logic reset_n;
    lecr_pkg::lecr_access_type access;
    logic [7:0] read_data;
    logic pin;
    lecr_pkg::lecr_frame_errors_type ferr;
    logic eye_poor;
    logic relock;
    logic [2:0] auto_div;
    logic [5:0] level;
    logic lc_mode;
    logic eq_active;
    lecr_pkg::lecr_clocking_type clock_controls;
    logic [2:0] stage1;
    logic [2:0] stage2;
    logic locked;
    int errors;
    int cmp_count;
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] addr_tab [6] = '{8'h35, 8'h39, 8'h3a, 8'h41, 8'h44, 8'h45};
    logic [7:0] rst_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h60, 8'h88};
    logic [7:0] mask_tab [6] = '{8'h70, 8'h02, 8'hf0, 8'h1f, 8'hef, 8'hff};
    lecr_host u_host (.clock, .read_data, .access);
    lecr_registers #(.STEP_CYCLES(4)) u_dut (.clock, .reset_n, .access, .read_data,
        .long_cable_pin(pin), .frame_errors(ferr), .eye_poor, .lock_restore(relock),
        .auto_divider_select(auto_div), .first_stage_setting(stage1), .second_stage_setting(stage2),
        .equalizer_level(level), .long_cable_mode(lc_mode),
        .adaptive_equalizer_active(eq_active), .clock_controls, .locked);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic pulse(input int k);
        @(negedge clock);
        ferr = 3'(3'b100 >> k);
        @(negedge clock);
        ferr = 3'b000;
        wait_n(1);
    endtask
    task automatic relock_link();
        @(negedge clock);
        relock = 1'b1;
        @(negedge clock);
        relock = 1'b0;
    endtask
    function automatic logic [7:0] static_level(input logic [7:0] v);
        return {2'b00, v[7:5], v[3:1]};
    endfunction
    task automatic give_verdict();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #20000;
        errors++;
        give_verdict();
    end
    initial begin
        reset_n = 1'b0;
        pin = 1'b0;
        ferr = 3'b000;
        eye_poor = 1'b0;
        relock = 1'b0;
        auto_div = 3'h0;
        errors = 0;
        cmp_count = 0;
        void'($urandom(82761));
        wait_n(3);
        reset_n = 1'b1;
        // reset values, writable bits, unmapped read
        for (int i = 0; i < 6; i++) begin
            u_host.rd(addr_tab[i], r);
            chk(r, rst_tab[i]);
            d = 8'($urandom);
            u_host.wr(addr_tab[i], d);
            u_host.rd(addr_tab[i], r);
            chk(r, d & mask_tab[i]);
        end
        u_host.rd(8'h50, r);
        chk(r, 8'h00);
        $display("test registers done");
        d = 8'($urandom) | 8'h01;
        u_host.wr(8'h44, d);
        wait_n(2);
        chk({7'h0, eq_active}, 8'h00);
        chk({2'b00, level}, static_level(d));
        chk({5'h00, stage1}, {5'h00, d[7:5]});
        chk({5'h00, stage2}, {5'h00, d[3:1]});
        u_host.rd(8'h3b, r);
        chk(r, static_level(d));
        $display("test bypass done");
        pin = 1'b1;
        u_host.wr(8'h35, 8'h00);
        wait_n(3);
        chk({7'h0, lc_mode}, 8'h01);
        u_host.wr(8'h35, 8'h20);
        chk({7'h0, lc_mode}, 8'h00);
        $display("test long cable done");
        eye_poor = 1'b1;
        u_host.wr(8'h44, 8'h00);
        u_host.wr(8'h45, 8'h8a);
        u_host.wr(8'h35, 8'h40);
        wait_n(12);
        chk({2'b00, level}, 8'h0a);
        u_host.wr(8'h35, 8'h00);
        wait_n(12);
        chk({7'h0, level > 6'h0a}, 8'h01);
        u_host.wr(8'h35, 8'h60);
        wait_n(3);
        chk({2'b00, level}, 8'h00);
        u_host.wr(8'h35, 8'h00);
        pin = 1'b0;
        $display("test restart done");
        auto_div = 3'($urandom);
        d = 8'($urandom) | 8'h80;
        u_host.wr(8'h39, 8'h02);
        u_host.wr(8'h3a, d);
        wait_n(2);
        chk({3'b000, clock_controls}, {5'b00011, d[6:4]});
        u_host.wr(8'h3a, 8'h00);
        wait_n(2);
        chk({3'b000, clock_controls}, {5'b00010, auto_div});
        $display("test clocking done");
        u_host.wr(8'h41, 8'h13);
        relock_link();
        pulse(0);
        pulse(1);
        chk({7'h0, locked}, 8'h01);
        pulse(2);
        chk({7'h0, locked}, 8'h00);
        u_host.wr(8'h41, 8'h03);
        relock_link();
        chk({7'h0, locked}, 8'h01);
        pulse(2);
        chk({7'h0, locked}, 8'h00);
        $display("test errors done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
